// [pkg/i2c_flags_pkg.sv]
package i2c_flags_pkg;

	// Register indexes; the byte address is four times the index.
	localparam logic [2:0] IDX_STATUS = 3'h0;
	localparam logic [2:0] IDX_CTRL = 3'h1;
	localparam logic [2:0] IDX_DATA = 3'h2;
	localparam logic [2:0] IDX_EVST = 3'h3;
	localparam logic [2:0] IDX_EVMASK = 3'h4;
	localparam int WB_AW = 5;
	localparam int IDX_LO = 2;

	// Bit positions in the status byte.
	localparam int B_ACK = 0;
	localparam int B_GC = 1;
	localparam int B_AAS = 2;
	localparam int B_AL = 3;
	localparam int B_RSV = 4;
	localparam int B_SCP = 5;
	localparam int B_INTERRUPT_REQUEST_FLAG = 6;
	localparam int B_BUS_OCCUPIED_FLAG = 7;

	// Bit positions in the control register.
	localparam int C_MASTER = 0;
	localparam int C_TRS = 1;
	localparam int C_FS = 2;
	localparam int C_IE = 3;
	localparam int C_ADDR_LO = 8;
	localparam int C_ADDR_HI = 14;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// Event bits of the interrupt status and mask registers.
	localparam int EV_BYTE = 0;
	localparam int EV_ARB = 1;
	localparam int EV_MATCH = 2;
	localparam int EV_STOP = 3;
	localparam logic [3:0] EV_RESET = 4'h0;

	// Bit counter landmarks within one byte on the wire.
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_IDX = 4'h8;
	localparam logic [3:0] DONE_CNT = 4'h9;
	localparam logic [7:0] GEN_CALL = 8'h00;

	// Hold time of a generated start or stop condition.
	localparam int CLK_PERIOD_NS = 40;
	localparam int T_COND_NS = 4700;
	localparam logic [6:0] COND_LAST =
		7'((T_COND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);

	typedef enum logic [2:0] {
		SQ_IDLE, SQ_START1, SQ_START2, SQ_STOP1, SQ_STOP2
	} seq_e;

endpackage : i2c_flags_pkg

// [pkg/bus_line_if.sv]
`timescale 1ns/1ps
interface bus_line_if;
	logic sda;
	logic scl;
	logic start;
	logic stop;
	logic rise;
	logic fall;
	modport mon(output sda, scl, start, stop, rise, fall);
	modport core(input sda, scl, start, stop, rise, fall);
endinterface : bus_line_if

// [core/bus_line_monitor.sv]
`timescale 1ns/1ps
module bus_line_monitor
(
	// Clock, reset and enable.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	// Raw bus line levels.
	input wire logic i_sda,
	input wire logic i_scl,
	// Conditioned levels and events.
	bus_line_if.mon bl
);
	typedef struct packed {
		logic sda_m;
		logic sda_s;
		logic sda_p;
		logic scl_m;
		logic scl_s;
		logic scl_p;
		logic start;
		logic stop;
		logic rise;
		logic fall;
	} mon_s;

	mon_s s;
	mon_s n;

	// Events look only at the second stage and its delayed copy, so a
	// metastable first stage never reaches a comparator.
	always_comb
	begin
		n = s;
		n.sda_m = i_sda;
		n.sda_s = s.sda_m;
		n.sda_p = s.sda_s;
		n.scl_m = i_scl;
		n.scl_s = s.scl_m;
		n.scl_p = s.scl_s;
		n.start = s.scl_s && s.scl_p && s.sda_p && !s.sda_s;
		n.stop = s.scl_s && s.scl_p && !s.sda_p && s.sda_s;
		n.rise = s.scl_s && !s.scl_p;
		n.fall = !s.scl_s && s.scl_p;
	end

	// Lines idle high, so the pipeline resets to the released level.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			s <= '{sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, scl_m: 1'b1,
				scl_s: 1'b1, scl_p: 1'b1, default: 1'b0};
		else if (i_clk_en)
			s <= n;
	end

	// Levels are delayed to line up with the registered events.
	assign bl.sda = s.sda_p;
	assign bl.scl = s.scl_p;
	assign bl.start = s.start;
	assign bl.stop = s.stop;
	assign bl.rise = s.rise;
	assign bl.fall = s.fall;

endmodule : bus_line_monitor

// [core/i2c_bus_status_flags.sv]
`timescale 1ns/1ps
// What this block does
// - Receive mode drives stored acknowledge flag value.
// - Transmit mode captures receiver answer into flag.
// - General call in slave receive sets flag.
// - Own or general address sets match flag.
// - Match flag clears by read one, write zero.
// - Data write when transmitting or read when receiving clears GC, AAS, AL.
// - Master transmit mismatch at clock rise loses arbitration.
// - Arbitration flag clears by read one, write zero.
// - Prohibit bit zero with busy issues start/stop.
// - Prohibit bit reads one; writing one ignored.
// - Master sets interrupt flag: byte end, lost.
// - Slave with FS clear sets flag on match, then bytes.
// - Interrupt flag clears by read one, write zero.
// - Busy bit follows detected start and stop.
module i2c_bus_status_flags
	import i2c_flags_pkg::*;
(
	// Clock, reset and enable.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	// Wishbone classic slave.
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_sel,
	input wire logic [WB_AW-1:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Open-drain bus lines.
	input wire logic i_sda,
	input wire logic i_scl,
	output logic o_sda_o,
	output logic o_sda_oe,
	output logic o_scl_o,
	output logic o_scl_oe,
	// Interrupt request.
	output logic o_irq
);
	typedef struct packed {
		logic ack;
		logic [15:0] rdat;
		logic ackf;
		logic gcf;
		logic aasf;
		logic alf;
		logic interrupt_request_flag;
		logic bus_occupied_flag;
		logic [7:0] arm;
		logic [15:0] ctrl;
		logic [7:0] data;
		logic [3:0] cnt;
		logic first;
		logic in_ack;
		logic addressed;
		logic lost;
		logic [3:0] evst;
		logic [3:0] evmask;
		seq_e seq;
		logic [6:0] tcnt;
		logic sda_drv;
		logic scl_drv;
	} st_s;

	st_s s;
	st_s n;
	logic req;
	logic take;
	logic wr;
	logic rd;
	logic [2:0] idx;

	bus_line_if bl();

	bus_line_monitor u_mon (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_clk_en(i_clk_en),
		.i_sda(i_sda),
		.i_scl(i_scl),
		.bl(bl)
	);

	function automatic logic [2:0] reg_idx(input logic [WB_AW-1:0] a);
		reg_idx = a[WB_AW-1:IDX_LO];
	endfunction : reg_idx

	// The start/stop prohibit and the spare bit always read as one.
	function automatic logic [7:0] status_byte(input st_s v);
		status_byte = 8'h00;
		status_byte[B_ACK] = v.ackf;
		status_byte[B_GC] = v.gcf;
		status_byte[B_AAS] = v.aasf;
		status_byte[B_AL] = v.alf;
		status_byte[B_RSV] = 1'b1;
		status_byte[B_SCP] = 1'b1;
		status_byte[B_INTERRUPT_REQUEST_FLAG] = v.interrupt_request_flag;
		status_byte[B_BUS_OCCUPIED_FLAG] = v.bus_occupied_flag;
	endfunction : status_byte

	function automatic logic [15:0] read_mux(input st_s v,
		input logic [2:0] i);
		unique case (i)
			IDX_STATUS: read_mux = {8'h00, status_byte(v)};
			IDX_CTRL: read_mux = v.ctrl;
			IDX_DATA: read_mux = {8'h00, v.data};
			IDX_EVST: read_mux = {12'h000, v.evst};
			IDX_EVMASK: read_mux = {12'h000, v.evmask};
			default: read_mux = 16'h0000;
		endcase
	endfunction : read_mux

	// Data bit being placed on the line; bits go out MSB first.
	function automatic logic tx_bit(input logic [7:0] d,
		input logic [3:0] c);
		tx_bit = d[3'(LAST_BIT - c)];
	endfunction : tx_bit

	function automatic logic seq_sda(input seq_e q);
		seq_sda = (q != SQ_IDLE);
	endfunction : seq_sda

	function automatic logic seq_scl(input seq_e q);
		seq_scl = (q == SQ_START2) || (q == SQ_STOP1);
	endfunction : seq_scl

	// A request is taken at the edge where ack is already high, so the
	// write and any read side effect land on the master's sampling edge.
	assign req = i_wb_cyc && i_wb_stb;
	assign take = req && s.ack;
	assign idx = reg_idx(i_wb_adr);
	assign wr = take && i_wb_we;
	assign rd = take && !i_wb_we;

	// Software effects come first so that hardware sets below win.
	always_comb
	begin
		logic [7:0] byte_in;
		logic [3:0] ev;
		logic master;
		logic trs;
		logic fs;
		byte_in = {s.data[6:0], bl.sda};
		ev = 4'h0;
		master = s.ctrl[C_MASTER];
		trs = s.ctrl[C_TRS];
		fs = s.ctrl[C_FS];
		n = s;
		n.ack = req && !s.ack;
		if (req && !s.ack)
			n.rdat = read_mux(s, reg_idx(i_wb_adr));
		// Reading arms the clear; a later status write with i_wb_sel[0] set disarms it.
		if (rd && idx == IDX_STATUS)
			n.arm = s.rdat[7:0];
		if (wr && idx == IDX_STATUS && i_wb_sel[0])
		begin
			n.arm = 8'h00;
			n.ackf = i_wb_dat[B_ACK];
			if (!i_wb_dat[B_GC] && s.arm[B_GC])
				n.gcf = 1'b0;
			if (!i_wb_dat[B_AAS] && s.arm[B_AAS])
				n.aasf = 1'b0;
			if (!i_wb_dat[B_AL] && s.arm[B_AL])
				n.alf = 1'b0;
			if (!i_wb_dat[B_INTERRUPT_REQUEST_FLAG] && s.arm[B_INTERRUPT_REQUEST_FLAG])
				n.interrupt_request_flag = 1'b0;
			// A one in the prohibit bit leaves the sequencer alone.
			if (!i_wb_dat[B_SCP] && s.seq == SQ_IDLE)
			begin
				n.seq = i_wb_dat[B_BUS_OCCUPIED_FLAG] ? SQ_START1 : SQ_STOP1;
				n.tcnt = 7'h00;
			end
		end
		if (wr && idx == IDX_CTRL)
		begin
			if (i_wb_sel[0])
				n.ctrl[7:0] = i_wb_dat[7:0];
			if (i_wb_sel[1])
				n.ctrl[15:8] = i_wb_dat[15:8];
		end
		if ((wr && idx == IDX_DATA && i_wb_sel[0] && trs) ||
			(rd && idx == IDX_DATA && !trs))
		begin
			n.gcf = 1'b0;
			n.aasf = 1'b0;
			n.alf = 1'b0;
		end
		if (wr && idx == IDX_DATA && i_wb_sel[0])
			n.data = i_wb_dat[7:0];
		if (wr && idx == IDX_EVST && i_wb_sel[0])
			n.evst = s.evst & ~i_wb_dat[3:0];
		if (wr && idx == IDX_EVMASK && i_wb_sel[0])
			n.evmask = i_wb_dat[3:0];

		// Start restarts byte framing and ends any slave session.
		if (bl.start)
		begin
			n.bus_occupied_flag = 1'b1;
			n.cnt = 4'h0;
			n.first = 1'b1;
			n.in_ack = 1'b0;
			n.lost = 1'b0;
			n.addressed = 1'b0;
		end
		if (bl.stop)
		begin
			n.bus_occupied_flag = 1'b0;
			n.cnt = 4'h0;
			n.in_ack = 1'b0;
			n.addressed = 1'b0;
			ev[EV_STOP] = 1'b1;
		end
		if (bl.rise && s.bus_occupied_flag && !bl.start && !bl.stop)
		begin
			if (s.cnt <= LAST_BIT)
			begin
				if (master && trs && !s.lost &&
					tx_bit(s.data, s.cnt) != bl.sda)
				begin
					n.alf = 1'b1;
					n.lost = 1'b1;
					n.interrupt_request_flag = 1'b1;
					ev[EV_ARB] = 1'b1;
				end
				if (!trs)
					n.data = byte_in;
				if (s.first && s.cnt == LAST_BIT && !master && !trs)
				begin
					if (byte_in == GEN_CALL)
						n.gcf = 1'b1;
					if (byte_in == GEN_CALL ||
						s.data[6:0] == s.ctrl[C_ADDR_HI:C_ADDR_LO])
					begin
						n.aasf = 1'b1;
						n.addressed = 1'b1;
						ev[EV_MATCH] = 1'b1;
						if (!fs)
							n.interrupt_request_flag = 1'b1;
					end
				end
			end
			else if (s.cnt == ACK_IDX && trs)
				n.ackf = bl.sda;
			if (s.cnt < DONE_CNT)
				n.cnt = s.cnt + 4'h1;
		end
		if (bl.fall && s.bus_occupied_flag && !bl.start && !bl.stop)
		begin
			if (s.cnt == ACK_IDX)
				n.in_ack = 1'b1;
			else if (s.cnt == DONE_CNT)
			begin
				n.in_ack = 1'b0;
				n.cnt = 4'h0;
				n.first = 1'b0;
				n.lost = 1'b0;
				ev[EV_BYTE] = 1'b1;
				if (master || (s.addressed && !fs))
					n.interrupt_request_flag = 1'b1;
			end
		end
		n.evst = n.evst | ev;

		// Each step of a generated condition holds for the full time.
		if (s.seq != SQ_IDLE)
		begin
			if (s.tcnt == COND_LAST)
			begin
				n.tcnt = 7'h00;
				unique case (s.seq)
					SQ_START1: n.seq = SQ_START2;
					SQ_STOP1: n.seq = SQ_STOP2;
					default: n.seq = SQ_IDLE;
				endcase
			end
			else
				n.tcnt = s.tcnt + 7'h1;
		end

		// Outputs are registered from the next state, so they match it.
		n.sda_drv = seq_sda(n.seq) ||
			(n.in_ack && !n.ctrl[C_TRS] && !n.ackf &&
			(n.ctrl[C_MASTER] || n.addressed)) ||
			(n.ctrl[C_MASTER] && n.ctrl[C_TRS] && !n.lost && n.bus_occupied_flag &&
			!n.in_ack && n.cnt <= LAST_BIT && !tx_bit(n.data, n.cnt));
		n.scl_drv = seq_scl(n.seq);
	end

	// Software can only see a flag change after a clock edge with the enable high.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			s <= '{ctrl: CTRL_RESET, evst: EV_RESET, evmask: EV_RESET,
				seq: SQ_IDLE, default: '0};
		else if (i_clk_en)
			s <= n;
	end

	// Bus answers and pins; open drain only ever pulls low.
	assign o_wb_ack = s.ack;
	assign o_wb_dat = {16'h0000, s.rdat};
	assign o_sda_o = 1'b0;
	assign o_sda_oe = s.sda_drv;
	assign o_scl_o = 1'b0;
	assign o_scl_oe = s.scl_drv;
	assign o_irq = (s.interrupt_request_flag && s.ctrl[C_IE]) ||
		(|(s.evst & s.evmask));

	// Checks on the flag logic; frozen cycles are not judged.
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst || !i_clk_en);

	a_ack_slot_drive: assert property (
		s.in_ack && !s.ctrl[C_TRS] && !s.ackf && (s.ctrl[C_MASTER] ||
		s.addressed) |-> o_sda_oe && !o_sda_o)
		else $error("acknowledge slot not driven low");

	a_ack_capture: assert property (
		bl.rise && s.bus_occupied_flag && !bl.start && !bl.stop &&
		s.cnt == ACK_IDX && s.ctrl[C_TRS]
		|=> s.ackf == $past(bl.sda))
		else $error("receiver answer not captured");

	a_gen_call_set: assert property (
		bl.rise && s.bus_occupied_flag && !bl.start && !bl.stop && s.first &&
		s.cnt == LAST_BIT && !s.ctrl[C_MASTER] && !s.ctrl[C_TRS] &&
		{s.data[6:0], bl.sda} == GEN_CALL
		|=> s.gcf && s.aasf)
		else $error("general call not flagged");

	a_blind_clear_kept: assert property (
		wr && idx == IDX_STATUS && i_wb_sel[0] && !s.arm[B_AAS] &&
		s.aasf |=> s.aasf)
		else $error("match flag cleared without a read");

	a_data_auto_clear: assert property (
		rd && idx == IDX_DATA && !s.ctrl[C_TRS] && !bl.rise
		|=> !s.gcf && !s.aasf && !s.alf)
		else $error("data read left flags set");

	a_arb_lost_set: assert property (
		bl.rise && s.bus_occupied_flag && !bl.start && !bl.stop &&
		s.cnt <= LAST_BIT && s.ctrl[C_MASTER] && s.ctrl[C_TRS] &&
		!s.lost && tx_bit(s.data, s.cnt) != bl.sda
		|=> s.alf && s.interrupt_request_flag && s.evst[EV_ARB])
		else $error("arbitration loss missed");

	a_prohibit_reads_one: assert property (
		o_wb_ack && idx == IDX_STATUS |-> o_wb_dat[B_SCP])
		else $error("prohibit bit read as zero");

	a_start_issue: assert property (
		wr && idx == IDX_STATUS && i_wb_sel[0] && !i_wb_dat[B_SCP] &&
		i_wb_dat[B_BUS_OCCUPIED_FLAG] && s.seq == SQ_IDLE
		|=> s.seq == SQ_START1 && o_sda_oe && !o_scl_oe)
		else $error("start condition not begun");

	a_busy_on_start: assert property (
		bl.start ##1 !bl.stop [*2] |-> s.bus_occupied_flag)
		else $error("busy not set after start");

	a_master_byte_irq: assert property (
		bl.fall && s.bus_occupied_flag && !bl.start && !bl.stop &&
		s.cnt == DONE_CNT && s.ctrl[C_MASTER] |=> s.interrupt_request_flag)
		else $error("byte end did not request interrupt");

	a_irq_output: assert property (
		s.interrupt_request_flag && s.ctrl[C_IE] |-> o_irq)
		else $error("interrupt output low with flag set");

	c_start_seen: cover property (bl.start ##[1:1000] bl.stop);
	c_match_seen: cover property ($rose(s.aasf));
	c_arb_lost: cover property ($rose(s.alf));
	c_gen_stop: cover property (s.seq == SQ_STOP2 ##1 s.seq == SQ_IDLE);

endmodule : i2c_bus_status_flags

// [dv/i2c_bus_peer.sv]
`timescale 1ns/1ps
// Behavioural bus master on the far side; it only ever pulls lines low.
module i2c_bus_peer
(
	// Clock.
	input wire logic i_clk,
	// Wired line levels.
	input wire logic i_sda,
	// Pull-down enables.
	output logic o_sda_oe,
	output logic o_scl_oe
);
	localparam int QTR = 25;
	// Both lines start released.
	initial
	begin
		o_sda_oe = 1'b0;
		o_scl_oe = 1'b0;
	end
	// Slow phases leave room for the input synchronisers.
	task automatic hold();
		repeat (QTR) @(posedge i_clk);
	endtask : hold
	// Start; from a low clock it also serves as a repeated start.
	task automatic start();
		o_sda_oe <= 1'b0;
		hold();
		o_scl_oe <= 1'b0;
		hold();
		o_sda_oe <= 1'b1;
		hold();
		o_scl_oe <= 1'b1;
		hold();
	endtask : start
	// Eight bits MSB first, then the answer slot sampled with clock high.
	task automatic send(input logic [7:0] b, output logic ak);
		for (int i = 8; i >= 0; i--)
		begin
			o_sda_oe <= (i > 0) ? !b[i-1] : 1'b0;
			hold();
			o_scl_oe <= 1'b0;
			hold();
			ak = i_sda;
			o_scl_oe <= 1'b1;
			hold();
		end
	endtask : send
	// Stop: data rises while the clock is high.
	task automatic stop();
		o_sda_oe <= 1'b1;
		hold();
		o_scl_oe <= 1'b0;
		hold();
		o_sda_oe <= 1'b0;
		hold();
	endtask : stop
endmodule : i2c_bus_peer

// [dv/i2c_bus_status_flags_tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
	bad_count++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module i2c_bus_status_flags_tb;
	import i2c_flags_pkg::*;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [WB_AW-1:0] adr = '0;
	logic [31:0] wdat = '0;
	logic [31:0] rdat, rd;
	logic ack, irq, sda_oe, scl_oe, p_sda, p_scl, ak;
	logic [6:0] own;
	logic [7:0] dat;
	logic en = 1'b1;
	logic sda_o, scl_o;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int seed = 32'h0ea501cb;
	// Open-drain lines with pull-ups.
	wire logic sda = !(sda_oe | p_sda);
	wire logic scl = !(scl_oe | p_scl);
	// Clock of 40 ns.
	always #20 i_clk = !i_clk;
	i2c_bus_status_flags i2c_bus_status_flags_inst (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .i_clk_en(en), .i_wb_cyc(cyc),
		.i_wb_stb(cyc), .i_wb_we(we), .i_wb_sel(4'hf), .i_wb_adr(adr),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sda(sda),
		.i_scl(scl), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_scl_o(scl_o),
		.o_scl_oe(scl_oe), .o_irq(irq));
	i2c_bus_peer i2c_bus_peer_inst (.i_clk(i_clk), .i_sda(sda),
		.o_sda_oe(p_sda), .o_scl_oe(p_scl));
	// Verdict and end of run.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	// One classic cycle; the wait is bounded so a dead slave is seen.
	task automatic wb(input logic w, input logic [2:0] i, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		rd = rdat;
		cyc <= 1'b0;
		`CHK(ack, 1'b1)
	endtask : wb
	// Expected status byte; bits 5 and 4 always read one.
	function automatic logic [7:0] exs(input logic bsy, ir, as, gc, ak);
		exs = 8'h30;
		exs[B_BUS_OCCUPIED_FLAG] = bsy;
		exs[B_INTERRUPT_REQUEST_FLAG] = ir;
		exs[B_AAS] = as;
		exs[B_GC] = gc;
		exs[B_ACK] = ak;
	endfunction : exs
	// Status read and compare.
	task automatic st(input logic [7:0] e);
		wb(1'b0, IDX_STATUS, 32'h0);
		`CHK(rd[7:0], e)
	endtask : st
	// The level output is combinational, so look mid-cycle.
	task automatic ck_irq(input logic e);
		@(negedge i_clk);
		`CHK(irq, e)
	endtask : ck_irq
	// Hang guard, well above the length of all frames and conditions.
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			bad_count++;
			complete_run();
		end
	end
	// Main sequence.
	initial
	begin
		repeat (10) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		own = 7'($random(seed));
		if (own == 7'h00)
			own = 7'h11;
		dat = 8'($random(seed));
		st(exs(0, 0, 0, 0, 0));
		ck_irq(1'b0);
		wb(1'b1, IDX_STATUS, 32'ha0);
		repeat (10) @(posedge i_clk);
		`CHK({sda_oe, scl_oe}, 2'b00)
		st(exs(0, 0, 0, 0, 0));
		$display("test reset done");
		wb(1'b1, IDX_CTRL, {17'h0, own, 8'h08});
		i2c_bus_peer_inst.start();
		i2c_bus_peer_inst.send({own, 1'b0}, ak);
		`CHK(ak, 1'b0)
		ck_irq(1'b1);
		wb(1'b1, IDX_STATUS, 32'h20);
		st(exs(1, 1, 1, 0, 0));
		wb(1'b1, IDX_STATUS, 32'h20);
		st(exs(1, 0, 0, 0, 0));
		ck_irq(1'b0);
		i2c_bus_peer_inst.send(dat, ak);
		`CHK(ak, 1'b0)
		st(exs(1, 1, 0, 0, 0));
		wb(1'b0, IDX_DATA, 32'h0);
		`CHK(rd[7:0], dat)
		$display("test own address done");
		wb(1'b1, IDX_STATUS, 32'h21);
		i2c_bus_peer_inst.start();
		i2c_bus_peer_inst.send(GEN_CALL, ak);
		`CHK(ak, 1'b1)
		st(exs(1, 1, 1, 1, 1));
		wb(1'b0, IDX_DATA, 32'h0);
		st(exs(1, 1, 0, 0, 1));
		wb(1'b1, IDX_STATUS, 32'h20);
		i2c_bus_peer_inst.stop();
		st(exs(0, 0, 0, 0, 0));
		$display("test general call done");
		wb(1'b0, IDX_EVST, 32'h0);
		`CHK(rd[3:0], 4'hd)
		wb(1'b1, IDX_CTRL, {17'h0, own, 8'h00});
		wb(1'b1, IDX_EVMASK, 32'h4);
		ck_irq(1'b1);
		wb(1'b1, IDX_EVST, 32'hf);
		ck_irq(1'b0);
		wb(1'b0, IDX_EVST, 32'h0);
		`CHK(rd, 32'h0)
		wb(1'b0, 3'h5, 32'h0);
		`CHK(rd, 32'h0)
		$display("test events done");
		`CHK({sda_o, scl_o}, 2'b00)
		// A frozen block must not answer a request that stands meanwhile.
		@(posedge i_clk);
		en <= 1'b0;
		cyc <= 1'b1;
		repeat (5) @(posedge i_clk);
		`CHK(ack, 1'b0)
		en <= 1'b1;
		cyc <= 1'b0;
		$display("test clock enable done");
		wb(1'b1, IDX_STATUS, 32'h80);
		repeat (5) @(posedge i_clk);
		`CHK({sda_oe, scl_oe}, 2'b10)
		repeat (300) @(posedge i_clk);
		st(exs(1, 0, 0, 0, 0));
		wb(1'b1, IDX_STATUS, 32'h00);
		repeat (5) @(posedge i_clk);
		`CHK({sda_oe, scl_oe}, 2'b11)
		repeat (300) @(posedge i_clk);
		st(exs(0, 0, 0, 0, 0));
		$display("test start stop done");
		// The block sends a released first bit while the peer pulls low.
		wb(1'b1, IDX_DATA, 32'h80);
		wb(1'b1, IDX_CTRL, {17'h0, own, 8'h03});
		i2c_bus_peer_inst.start();
		i2c_bus_peer_inst.send(8'h00, ak);
		st(exs(1, 1, 0, 0, 1) | 8'h08);
		wb(1'b1, IDX_STATUS, 32'h20);
		st(exs(1, 0, 0, 0, 0));
		i2c_bus_peer_inst.stop();
		wb(1'b0, IDX_EVST, 32'h0);
		`CHK(rd[3:0], 4'hb)
		$display("test arbitration done");
		complete_run();
	end
endmodule : i2c_bus_status_flags_tb
